// file: hw/tme_defines.svh
// Register offsets, field positions, reset values and timing counts of the tap/motion block
`ifndef TME_DEFINES_SVH
`define TME_DEFINES_SVH

// Register offsets
`define TME_ADDR_TAP_THR 6'h1D
`define TME_ADDR_TAP_DUR 6'h21
`define TME_ADDR_HOLDOFF 6'h22
`define TME_ADDR_WINDOW 6'h23
`define TME_ADDR_AXIS_SEL 6'h2A
`define TME_ADDR_REPORT 6'h2B
`define TME_ADDR_EV_EN 6'h2E
`define TME_ADDR_EV_SRC 6'h30

// Event bit positions, shared by enable, routing and source bytes
`define TME_EV_DRDY 7
`define TME_EV_SINGLE 6
`define TME_EV_DOUBLE 5
`define TME_EV_ACT 4
`define TME_EV_INACT 3
`define TME_EV_FF 2
`define TME_EV_WM 1
`define TME_EV_OVR 0

// Source bits that a read of the source register clears
`define TME_SRC_RDCLR_MASK 8'h7C

// Axis select fields
`define TME_AX_SUPPRESS 3
`define TME_AX_X 2
`define TME_AX_Y 1
`define TME_AX_Z 0

// First-axis report fields
`define TME_RPT_ASLEEP 3

// Reset value of every stored byte
`define TME_RST_BYTE 8'h00

// Threshold LSB is this many powers of two above an acceleration LSB
`define TME_THR_SHIFT 4

// Undecimated sample rate and timing register scales
`define TME_SMP_RATE_HZ 3200
`define TME_DUR_LSB_US 625
`define TME_LAT_LSB_US 1250
`define TME_DUR_TICKS ((`TME_DUR_LSB_US * `TME_SMP_RATE_HZ) / 1000000)
`define TME_LAT_TICKS ((`TME_LAT_LSB_US * `TME_SMP_RATE_HZ) / 1000000)

// Decimation shift used while asleep
`define TME_SLEEP_SHIFT 4'h9

`endif

// file: hw/tme_pkg.sv
// Types shared by the tap/motion block
package tme_pkg;
  typedef logic [7:0] tme_byte_t;
  typedef logic [10:0] tme_cnt_t;
  typedef enum logic [2:0] {ST_IDLE, ST_TAP1, ST_HOLDOFF, ST_WINDOW, ST_TAP2, ST_QUIET} tme_tap_e;
endpackage

// file: hw/tme_hit_if.sv
// Per-axis threshold hits passed from the comparator to the tap logic
interface tme_hit_if;
  logic [2:0] hit;
  logic above;
  modport src (output hit, output above);
  modport snk (input hit, input above);
endinterface

// file: hw/tme_axis_cmp.sv
// Magnitude comparison of the three axes against the tap threshold
module tme_axis_cmp
  import tme_pkg::*;
(
  input wire logic signed [15:0] i_acc_x,
  input wire logic signed [15:0] i_acc_y,
  input wire logic signed [15:0] i_acc_z,
  input wire tme_byte_t i_thr,
  input wire logic [2:0] i_axis_en,
  tme_hit_if.src o_hit
);
  `include "tme_defines.svh"

  // Seventeen bits so that the most negative sample has a true magnitude
  function automatic logic [16:0] tme_mag(input logic signed [15:0] a);
    logic [16:0] ext;
    ext = {a[15], a};
    return a[15] ? 17'(~ext + 17'h00001) : ext;
  endfunction

  wire logic [16:0] thr_scaled = 17'({i_thr, 4'h0});

  // Masked axes never hit, so they cannot start or extend a tap
  wire logic hit_x = i_axis_en[2] && (tme_mag(i_acc_x) > thr_scaled);
  wire logic hit_y = i_axis_en[1] && (tme_mag(i_acc_y) > thr_scaled);
  wire logic hit_z = i_axis_en[0] && (tme_mag(i_acc_z) > thr_scaled);
  // One driver for the whole hit vector
  assign o_hit.hit = {hit_x, hit_y, hit_z};
  assign o_hit.above = hit_x || hit_y || hit_z;
endmodule

// file: hw/tme_decim.sv
// Output-rate strobe made by decimating the undecimated sample strobe
module tme_decim
  import tme_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_smp_valid,
  input wire logic [3:0] i_shift,
  output logic o_out_valid
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic out_ff;

  // Rate is 2^shift below the sampling rate
  wire logic [15:0] cnt_mask = 16'((17'h00001 << i_shift) - 17'h00001);
  wire logic wrap = i_smp_valid && ((cnt_ff & cnt_mask) == cnt_mask);

  assign nxt_cnt = wrap ? 16'h0000 : (i_smp_valid ? 16'(cnt_ff + 16'h0001) : cnt_ff);

  // Counter and strobe register
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      cnt_ff <= 16'h0000;
      out_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      out_ff <= wrap;
    end
  end

  assign o_out_valid = out_ff;
endmodule

// file: hw/tme_top.sv
// Tap detection, activity/inactivity linking, sleep control and event registers
module tme_top
  import tme_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_smp_valid,
  input wire logic signed [15:0] i_acc_x,
  input wire logic signed [15:0] i_acc_y,
  input wire logic signed [15:0] i_acc_z,
  input wire logic i_act_hit,
  input wire logic [2:0] i_act_axes,
  input wire logic i_inact_hit,
  input wire logic i_ff_hit,
  input wire logic i_fifo_wm,
  input wire logic i_fifo_ovr,
  input wire logic i_data_read,
  input wire logic i_link_en,
  input wire logic i_autosleep_en,
  input wire logic i_sleep_en,
  input wire logic [3:0] i_rate_shift,
  input wire tme_byte_t i_event_route,
  input wire logic [5:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire tme_byte_t i_reg_wdata,
  output tme_byte_t o_reg_rdata,
  output logic o_event_out_a,
  output logic o_event_out_b,
  output logic o_asleep,
  output logic o_out_valid
);
  `include "tme_defines.svh"

  // Timing register value scaled to sample ticks
  function automatic tme_cnt_t tme_lim(input tme_byte_t v, input int unsigned k);
    return tme_cnt_t'(v * k);
  endfunction

  tme_byte_t thr_ff, dur_ff, hold_ff, win_ff, axis_ff, rpt_ff, en_ff, src_ff, rdata_ff;
  tme_byte_t nxt_src, nxt_rpt, set_vec, clr_vec;
  tme_tap_e tap_st_ff, nxt_tap_st;
  tme_cnt_t cnt_ff, nxt_cnt;
  logic [2:0] first_ff, nxt_first;
  logic act_arm_ff, inact_arm_ff, asleep_ff;
  logic nxt_act_arm, nxt_inact_arm, nxt_asleep;
  logic tap_single, tap_double;
  logic smp_out;

  tme_hit_if hit_bus ();

  tme_axis_cmp u_cmp (
    .i_acc_x(i_acc_x),
    .i_acc_y(i_acc_y),
    .i_acc_z(i_acc_z),
    .i_thr(thr_ff),
    .i_axis_en(axis_ff[2:0]),
    .o_hit(hit_bus.src)
  );

  // Sleep drops to a fixed low rate, waking restores the programmed one
  wire logic [3:0] eff_shift = asleep_ff ? `TME_SLEEP_SHIFT : i_rate_shift;

  tme_decim u_decim (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_smp_valid(i_smp_valid),
    .i_shift(eff_shift),
    .o_out_valid(smp_out)
  );

  // Register decode
  wire logic wr_thr = i_reg_wr && (i_reg_addr == `TME_ADDR_TAP_THR);
  wire logic wr_dur = i_reg_wr && (i_reg_addr == `TME_ADDR_TAP_DUR);
  wire logic wr_hold = i_reg_wr && (i_reg_addr == `TME_ADDR_HOLDOFF);
  wire logic wr_win = i_reg_wr && (i_reg_addr == `TME_ADDR_WINDOW);
  wire logic wr_axis = i_reg_wr && (i_reg_addr == `TME_ADDR_AXIS_SEL);
  wire logic wr_en = i_reg_wr && (i_reg_addr == `TME_ADDR_EV_EN);
  wire logic rd_src = i_reg_rd && (i_reg_addr == `TME_ADDR_EV_SRC);

  // Read mux; unmapped offsets read as zero
  wire tme_byte_t rd_mux =
    (i_reg_addr == `TME_ADDR_TAP_THR) ? thr_ff :
    (i_reg_addr == `TME_ADDR_TAP_DUR) ? dur_ff :
    (i_reg_addr == `TME_ADDR_HOLDOFF) ? hold_ff :
    (i_reg_addr == `TME_ADDR_WINDOW) ? win_ff :
    (i_reg_addr == `TME_ADDR_AXIS_SEL) ? axis_ff :
    (i_reg_addr == `TME_ADDR_REPORT) ? rpt_ff :
    (i_reg_addr == `TME_ADDR_EV_EN) ? en_ff :
    (i_reg_addr == `TME_ADDR_EV_SRC) ? src_ff : `TME_RST_BYTE;

  // Tap control decode
  wire logic single_on = en_ff[`TME_EV_SINGLE];
  wire logic double_on = en_ff[`TME_EV_DOUBLE];
  wire logic tap_on = single_on || double_on;
  // Zero holdoff or window would give a window that never opens
  wire logic double_ok = double_on && (hold_ff != 8'h00) && (win_ff != 8'h00);
  wire logic suppress = axis_ff[`TME_AX_SUPPRESS];
  wire logic above = hit_bus.above;
  wire tme_cnt_t dur_lim = tme_lim(dur_ff, `TME_DUR_TICKS);
  wire tme_cnt_t hold_lim = tme_lim(hold_ff, `TME_LAT_TICKS);
  wire tme_cnt_t win_lim = tme_lim(win_ff, `TME_LAT_TICKS);
  wire tme_cnt_t cnt_inc = tme_cnt_t'(cnt_ff + 11'h001);
  wire logic dur_over = above && (cnt_ff >= dur_lim);

  // Tap sequencer; it moves only on full-rate samples, except that turning both tap enables off drops it to ST_IDLE at once
  always_comb
  begin
    nxt_tap_st = tap_st_ff;
    nxt_cnt = cnt_ff;
    nxt_first = first_ff;
    tap_single = 1'b0;
    tap_double = 1'b0;
    if (!tap_on)
    begin
      nxt_tap_st = ST_IDLE;
      nxt_cnt = 11'h000;
    end
    else if (i_smp_valid)
    begin
      unique case (tap_st_ff)
        ST_IDLE:
        begin
          if (above)
          begin
            nxt_tap_st = ST_TAP1;
            nxt_cnt = 11'h001;
            nxt_first = hit_bus.hit;
          end
        end
        ST_TAP1:
        begin
          if (dur_over)
            nxt_tap_st = ST_QUIET;
          else if (above)
            nxt_cnt = cnt_inc;
          else if (double_ok)
          begin
            nxt_tap_st = ST_HOLDOFF;
            nxt_cnt = 11'h000;
          end
          else
          begin
            tap_single = 1'b1;
            nxt_tap_st = ST_IDLE;
          end
        end
        ST_HOLDOFF:
        begin
          if (above && suppress)
          begin
            tap_single = 1'b1;
            nxt_tap_st = ST_QUIET;
          end
          else if (cnt_inc >= hold_lim)
          begin
            // Motion still present as the window opens is not a new tap
            tap_single = above;
            nxt_tap_st = above ? ST_QUIET : ST_WINDOW;
            nxt_cnt = 11'h000;
          end
          else
            nxt_cnt = cnt_inc;
        end
        ST_WINDOW:
        begin
          if (above)
          begin
            nxt_tap_st = ST_TAP2;
            nxt_cnt = 11'h001;
          end
          else if (cnt_inc >= win_lim)
          begin
            tap_single = 1'b1;
            nxt_tap_st = ST_IDLE;
          end
          else
            nxt_cnt = cnt_inc;
        end
        ST_TAP2:
        begin
          if (dur_over)
          begin
            tap_single = 1'b1;
            nxt_tap_st = ST_QUIET;
          end
          else if (above)
            nxt_cnt = cnt_inc;
          else
          begin
            tap_single = 1'b1;
            tap_double = 1'b1;
            nxt_tap_st = ST_IDLE;
          end
        end
        ST_QUIET:
        begin
          if (!above)
            nxt_tap_st = ST_IDLE;
        end
      endcase
    end
  end

  // Event qualification
  wire logic single_ev = tap_single && single_on;
  wire logic double_ev = tap_double && double_on;
  wire logic tap_ev = single_ev || double_ev;
  wire logic act_ev = i_act_hit && en_ff[`TME_EV_ACT] && (!i_link_en || act_arm_ff);
  wire logic inact_ev = i_inact_hit && en_ff[`TME_EV_INACT] && (!i_link_en || inact_arm_ff);
  wire logic ff_ev = i_ff_hit && en_ff[`TME_EV_FF];
  wire logic manual_sleep = i_sleep_en && !i_autosleep_en;
  wire logic auto_ok = i_sleep_en && i_autosleep_en && i_link_en;

  // Source bits 7:2 are sticky and a new event beats a clear in the same cycle; bits 1:0 follow the FIFO inputs
  assign set_vec = {smp_out, single_ev, double_ev, act_ev, inact_ev, ff_ev, 2'b00};
  assign clr_vec = (rd_src ? `TME_SRC_RDCLR_MASK : 8'h00) | {i_data_read, 7'h00};
  assign nxt_src = {((src_ff[7:2] & ~clr_vec[7:2]) | set_vec[7:2]), i_fifo_wm, i_fifo_ovr};

  // Link arming swaps on each qualified event
  assign nxt_act_arm = act_ev ? 1'b0 : (inact_ev ? 1'b1 : act_arm_ff);
  assign nxt_inact_arm = act_ev ? 1'b1 : (inact_ev ? 1'b0 : inact_arm_ff);

  // Auto-sleep entry waits for a pending activity event to be read away
  assign nxt_asleep = manual_sleep ? 1'b1 :
                      !i_sleep_en ? 1'b0 :
                      (act_ev && i_link_en) ? 1'b0 :
                      (inact_ev && auto_ok && !src_ff[`TME_EV_ACT]) ? 1'b1 :
                      asleep_ff;

  // Report: tap axes only change on a tap event, asleep bit always live
  assign nxt_rpt = {1'b0, i_act_hit ? i_act_axes : rpt_ff[6:4], nxt_asleep,
                    tap_ev ? first_ff : rpt_ff[2:0]};

  // Host-written configuration
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      thr_ff <= `TME_RST_BYTE;
      dur_ff <= `TME_RST_BYTE;
      hold_ff <= `TME_RST_BYTE;
      win_ff <= `TME_RST_BYTE;
      axis_ff <= `TME_RST_BYTE;
      en_ff <= `TME_RST_BYTE;
    end
    else
    begin
      thr_ff <= wr_thr ? i_reg_wdata : thr_ff;
      dur_ff <= wr_dur ? i_reg_wdata : dur_ff;
      hold_ff <= wr_hold ? i_reg_wdata : hold_ff;
      win_ff <= wr_win ? i_reg_wdata : win_ff;
      axis_ff <= wr_axis ? i_reg_wdata : axis_ff;
      en_ff <= wr_en ? i_reg_wdata : en_ff;
    end
  end

  // Block state and read data
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      tap_st_ff <= ST_IDLE;
      cnt_ff <= 11'h000;
      first_ff <= 3'h0;
      src_ff <= `TME_RST_BYTE;
      rpt_ff <= `TME_RST_BYTE;
      rdata_ff <= `TME_RST_BYTE;
      act_arm_ff <= 1'b0;
      inact_arm_ff <= 1'b1;
      asleep_ff <= 1'b0;
    end
    else
    begin
      tap_st_ff <= nxt_tap_st;
      cnt_ff <= nxt_cnt;
      first_ff <= nxt_first;
      src_ff <= nxt_src;
      rpt_ff <= nxt_rpt;
      rdata_ff <= i_reg_rd ? rd_mux : rdata_ff;
      act_arm_ff <= nxt_act_arm;
      inact_arm_ff <= nxt_inact_arm;
      asleep_ff <= nxt_asleep;
    end
  end

  // Enabled pending events split by route bit
  wire tme_byte_t live_ev = src_ff & en_ff;
  assign o_event_out_a = |(live_ev & ~i_event_route);
  assign o_event_out_b = |(live_ev & i_event_route);
  assign o_reg_rdata = rdata_ff;
  assign o_asleep = asleep_ff;
  assign o_out_valid = smp_out;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  chk_single_fall: assert property (
    (single_on && !double_on && i_smp_valid && tap_st_ff == ST_TAP1 && !above)
    |=> src_ff[`TME_EV_SINGLE] && tap_st_ff == ST_IDLE)
    else $error("single tap not raised on fall");

  chk_single_delayed: assert property (
    (double_ok && i_smp_valid && tap_st_ff == ST_TAP1 && !above && !dur_over)
    |=> tap_st_ff == ST_HOLDOFF && !$rose(src_ff[`TME_EV_SINGLE]))
    else $error("single tap not held back for double attempt");

  chk_suppress_holdoff: assert property (
    (tap_on && i_smp_valid && tap_st_ff == ST_HOLDOFF && above && suppress)
    |=> tap_st_ff == ST_QUIET ##1 !$rose(src_ff[`TME_EV_DOUBLE]))
    else $error("suppress did not cancel double tap");

  chk_window_busy: assert property (
    (tap_on && i_smp_valid && tap_st_ff == ST_HOLDOFF && !suppress && above &&
     cnt_inc >= hold_lim) |=> tap_st_ff == ST_QUIET)
    else $error("busy window start not rejected");

  chk_tap2_long: assert property (
    (tap_on && i_smp_valid && tap_st_ff == ST_TAP2 && dur_over)
    |=> tap_st_ff == ST_QUIET && !src_ff[`TME_EV_DOUBLE] || $past(src_ff[`TME_EV_DOUBLE]))
    else $error("overlong second tap accepted");

  chk_double_set: assert property (
    (double_on && i_smp_valid && tap_st_ff == ST_TAP2 && !above)
    |=> src_ff[`TME_EV_DOUBLE] && (src_ff[`TME_EV_SINGLE] || !single_on))
    else $error("double tap not reported");

  chk_report_axes: assert property (
    tap_ev |=> rpt_ff[2:0] == $past(first_ff))
    else $error("first axis not recorded");

  chk_axis_mask: assert property (
    ((hit_bus.hit & ~axis_ff[2:0]) == 3'h0) && ((axis_ff[2:0] != 3'h0) || !above))
    else $error("masked axis reported a hit");

  chk_no_autosleep: assert property (
    (!asleep_ff && src_ff[`TME_EV_ACT] && i_autosleep_en) |=> !asleep_ff)
    else $error("entered sleep with activity pending");

  chk_wake_act: assert property (
    (asleep_ff && act_ev && i_link_en && i_autosleep_en)
    |=> !asleep_ff && src_ff[`TME_EV_ACT] && inact_arm_ff && !act_arm_ff)
    else $error("activity did not wake the block");

  chk_read_clear: assert property (
    (rd_src && set_vec[6:2] == 5'h00) |=> src_ff[6:2] == 5'h00)
    else $error("source read did not clear events");

  cov_single: cover property (single_ev && !double_on);
  cov_double: cover property (double_ev);
  cov_sleep: cover property ($rose(asleep_ff) && i_autosleep_en);
  cov_wake: cover property ($fell(asleep_ff) && i_link_en);
endmodule

// file: tb/tme_host_model.sv
// Host model that reaches the event block's registers
module tme_host_model
  import tme_pkg::*;
(
  input wire logic i_mclk,
  input wire tme_byte_t i_rdata,
  output logic [5:0] o_addr = 6'h00,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output tme_byte_t o_wdata = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;

  // Write one byte; data turns over once its taking edge has passed
  task automatic wr(input logic [5:0] a, input tme_byte_t d);
    @(negedge i_mclk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_mclk);
    o_wr = 1'b0;
    o_wdata = ~d; // Stale data never repeats the last byte
  endtask

  // Read one byte; reading the source byte is how tap and motion events get cleared
  task automatic rd(input logic [5:0] a, output tme_byte_t d);
    @(negedge i_mclk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_mclk);
    d = i_rdata;
    o_rd = 1'b0;
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the tap and motion event block
`include "tme_defines.svh"
module testbench
  import tme_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Tap timing in samples: duration 0x11, holdoff 0x11 and window 0x41
  localparam int D = 34;
  localparam int H = 68;
  localparam int W = 260;
  localparam logic [5:0] SRC = `TME_ADDR_EV_SRC;
  localparam logic [5:0] RPT = `TME_ADDR_REPORT;
  logic clk = 1'b0, rst = 1'b1, smp = 1'b0, act = 1'b0, inact = 1'b0, data_rd = 1'b0;
  logic link = 1'b0, asl_en = 1'b0, slp_en = 1'b0;
  logic signed [15:0] ax = 16'sh0000, ay = 16'sh0000, az = 16'sh0000;
  logic [2:0] act_ax = 3'h0;
  logic [3:0] shift = 4'h0;
  tme_byte_t route = 8'h00, rv, wdata, rdata;
  logic [5:0] addr;
  logic wr, rd, out_a, out_b, asleep, out_valid;
  int num_errors = 0, check_count = 0, ov_cnt = 0, ov_base = 0;
  logic [5:0] rw_a [6] = '{`TME_ADDR_TAP_THR, `TME_ADDR_TAP_DUR, `TME_ADDR_HOLDOFF,
    `TME_ADDR_WINDOW, `TME_ADDR_AXIS_SEL, `TME_ADDR_EV_EN};

  // Block under test and the host that programs it
  tme_top dut_u (
    .i_mclk(clk), .i_sys_rst(rst), .i_smp_valid(smp), .i_acc_x(ax), .i_acc_y(ay),
    .i_acc_z(az), .i_act_hit(act), .i_act_axes(act_ax), .i_inact_hit(inact),
    .i_ff_hit(1'b0), .i_fifo_wm(1'b0), .i_fifo_ovr(1'b0), .i_data_read(data_rd),
    .i_link_en(link), .i_autosleep_en(asl_en), .i_sleep_en(slp_en), .i_rate_shift(shift),
    .i_event_route(route), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_event_out_a(out_a),
    .o_event_out_b(out_b), .o_asleep(asleep), .o_out_valid(out_valid)
  );
  tme_host_model host_u (
    .i_mclk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata)
  );

  // Free-running 40 MHz clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // Decimated strobes seen since the start of the run; never cleared
  always @(posedge clk)
    if (out_valid === 1'b1)
      ov_cnt <= ov_cnt + 1;

  // Compare one result byte
  task automatic chk(input string what, input tme_byte_t exp, input tme_byte_t got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Read a register and compare the masked bits
  task automatic rdchk(input logic [5:0] a, input tme_byte_t m, input tme_byte_t e,
    input string what);
    host_u.rd(a, rv);
    chk(what, e, rv & m);
  endtask

  // One full-rate sample; axes in hot sit well above the threshold
  task automatic smp_put(input logic [2:0] hot);
    @(negedge clk);
    smp = 1'b1;
    ax = hot[2] ? -16'sh07D0 : 16'sh0028; // Negative swing checks magnitude
    ay = hot[1] ? 16'sh07D0 : -16'sh0028;
    az = hot[0] ? 16'sh07D0 : 16'sh0028;
    @(negedge clk);
    smp = 1'b0;
  endtask

  task automatic quiet(input int n);
    repeat (n) smp_put(3'b000);
  endtask

  // A tap of n samples above, one below, then a cycle for the flag to land
  task automatic taps(input int n, input logic [2:0] hot);
    repeat (n) smp_put(hot);
    smp_put(3'b000);
    @(negedge clk);
  endtask

  // Generous tap settings, holdoff and window nonzero so pairs can work
  task automatic cfg(input tme_byte_t en, input tme_byte_t sel);
    host_u.wr(`TME_ADDR_TAP_THR, 8'h31);
    host_u.wr(`TME_ADDR_TAP_DUR, 8'h11);
    host_u.wr(`TME_ADDR_HOLDOFF, 8'h11);
    host_u.wr(`TME_ADDR_WINDOW, 8'h41);
    host_u.wr(`TME_ADDR_AXIS_SEL, sel);
    host_u.wr(`TME_ADDR_EV_EN, en);
    host_u.rd(SRC, rv);
  endtask

  // Activity or inactivity pulse from the motion comparators
  task automatic ev(input logic a, input logic [2:0] axs);
    @(negedge clk);
    act = a;
    inact = ~a;
    act_ax = axs;
    @(negedge clk);
    act = 1'b0;
    inact = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // Tap, gap, tap, gap, tap, then settle and judge the pair flags
  task automatic dbl(input tme_byte_t sel, input int g1, input int n1, input int g2,
    input int n2, input tme_byte_t e);
    cfg(8'h60, sel);
    taps(3, 3'b100);
    quiet(g1);
    if (n1 > 0)
      taps(n1, 3'b100);
    quiet(g2);
    if (n2 > 0)
      taps(n2, 3'b100);
    quiet(H + W + 8);
    rdchk(SRC, 8'h60, e, "tap pair");
  endtask

  // Reset values, read-back, read-only bytes and an unmapped address
  task automatic t_regs;
    foreach (rw_a[i])
    begin
      rdchk(rw_a[i], 8'hFF, 8'h00, "reset byte");
      host_u.wr(rw_a[i], 8'hC3 ^ {2'b00, rw_a[i]});
      rdchk(rw_a[i], 8'hFF, 8'hC3 ^ {2'b00, rw_a[i]}, "rw byte");
    end
    host_u.wr(RPT, 8'hFF);
    rdchk(RPT, 8'hFF, 8'h00, "report");
    host_u.wr(SRC, 8'hFF);
    rdchk(SRC, 8'hFF, 8'h00, "source");
    rdchk(6'h3F, 8'hFF, 8'h00, "unmapped");
  endtask

  // Single taps: axis report, clearing, idle axes, overlong tap, enables, routing
  task automatic t_single;
    cfg(8'h40, 8'h04);
    taps(3, 3'b100);
    chk("out a", 8'h01, {7'h00, out_a});
    chk("out b", 8'h00, {7'h00, out_b});
    rdchk(RPT, 8'h07, 8'h04, "tap axis");
    rdchk(SRC, 8'h7C, 8'h40, "single");
    rdchk(SRC, 8'h7C, 8'h00, "cleared");
    taps(3, 3'b011);
    rdchk(SRC, 8'h7C, 8'h00, "idle axes");
    rdchk(RPT, 8'h07, 8'h04, "report kept");
    taps(D + 2, 3'b100);
    rdchk(SRC, 8'h7C, 8'h00, "long tap");
    cfg(8'h00, 8'h04);
    taps(3, 3'b100);
    rdchk(SRC, 8'h7C, 8'h00, "taps off");
    route = 8'hFF;
    cfg(8'h40, 8'h07);
    taps(3, 3'b011);
    chk("routed b", 8'h01, {7'h00, out_b});
    rdchk(RPT, 8'h07, 8'h03, "two axes");
    route = 8'h00;
  endtask

  // Tap pairs: valid, late start, holdoff spikes, window opening, overlong
  task automatic t_double;
    cfg(8'h60, 8'h04);
    taps(3, 3'b100);
    quiet(4);
    chk("single held", 8'h00, {7'h00, out_a});
    quiet(H + W + 8);
    rdchk(SRC, 8'h60, 8'h40, "window lapsed");
    dbl(8'h04, H + 4, 3, 0, 0, 8'h60);
    dbl(8'h04, H + W - 6, D - 2, 0, 0, 8'h60);
    dbl(8'h04, H / 2, 2, H / 2 + 4, 3, 8'h60);
    dbl(8'h0C, H / 2, 2, H / 2 + 4, 3, 8'h40);
    dbl(8'h04, H - 3, 8, 0, 0, 8'h40);
    dbl(8'h04, H + 4, D + 4, 0, 0, 8'h40);
  endtask

  // Output strobe decimation against full-rate detection and sample-ready flag
  task automatic t_rate;
    cfg(8'h40, 8'h04);
    shift = 4'h2;
    quiet(2);
    ov_base = ov_cnt; // Snapshot only, the counter has one writer
    quiet(16);
    @(negedge clk);
    chk("strobes", 8'h04, 8'(ov_cnt - ov_base));
    shift = 4'h3;
    taps(1, 3'b100);
    rdchk(SRC, 8'hC0, 8'hC0, "short tap");
    data_rd = 1'b1;
    @(negedge clk);
    data_rd = 1'b0;
    rdchk(SRC, 8'h80, 8'h00, "sample taken");
  endtask

  // Link mode: sleep on inactivity, wake on activity, no sleep while it pends
  task automatic t_sleep;
    link = 1'b1;
    slp_en = 1'b1;
    asl_en = 1'b1;
    host_u.wr(`TME_ADDR_EV_EN, 8'h18);
    host_u.rd(SRC, rv);
    ev(1'b1, 3'b111);
    rdchk(SRC, 8'h18, 8'h00, "act unarmed");
    ev(1'b0, 3'b000);
    chk("asleep", 8'h01, {7'h00, asleep});
    rdchk(RPT, 8'h08, 8'h08, "asleep bit");
    rdchk(SRC, 8'h18, 8'h08, "inact");
    ev(1'b0, 3'b000);
    rdchk(SRC, 8'h18, 8'h00, "inact unarmed");
    ev(1'b1, 3'b101);
    chk("awake", 8'h00, {7'h00, asleep});
    chk("act out", 8'h01, {7'h00, out_a});
    rdchk(RPT, 8'h78, 8'h50, "act axes");
    ev(1'b0, 3'b000);
    chk("act pending", 8'h00, {7'h00, asleep});
    rdchk(SRC, 8'h18, 8'h18, "both");
    // Inactivity stays disarmed until activity is seen again
    ev(1'b1, 3'b001);
    host_u.rd(SRC, rv);
    ev(1'b0, 3'b000);
    chk("asleep again", 8'h01, {7'h00, asleep});
  endtask

  // Counts, verdict and end of run
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Reset for three cycles, then the scenarios in turn
  initial
  begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_regs;
    t_single;
    t_double;
    t_rate;
    t_sleep;
    complete_run;
  end

  // Hang guard well past the longest expected run
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    complete_run;
  end
endmodule
